/* core/bms_clkdiv.sv */
// divide-by-two enable generator for the internal bus rate
// assumes the oscillator-rate clock and synchronous reset
`timescale 1ns/1ps
module bms_clkdiv
(
  input wire logic clock,  // oscillator-rate clock
  input wire logic rst_n,  // synchronous reset, active low
  output logic bus_ce      // one-cycle pulse every second clock
);

  // ----------------------------------------------------------------
  // toggle divider
  // ----------------------------------------------------------------
  // a toggle flop gives exactly half rate with no counter
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      bus_ce <= 1'b0;
    else
      bus_ce <= !bus_ce;
  end

  chk_ce_alternates : assert property (@(posedge clock) disable iff (!rst_n) bus_ce |=> !bus_ce)
    else $error("bus enable not at half rate");

endmodule

/* core/bms_pkg.sv */
// shared constants and types for the boot mode selector and eprom copier
// assumes one 20 MHz clock, synchronous active-low reset, pins already synchronous
//
// Behaviour
// - reset release samples vpp and selects, decodes bootloader
// - normal vpp level at release gives single chip
// - single chip keeps all bus activity internal
// - single chip fetches vectors from on-chip eprom
// - external address comes through two port-loaded latches
// - full programming pass, then full verify pass
// - port c bits 0,1 drive the indicators
// - program indicator on, off when verify starts
// - verify indicator only if every byte matches
// - first mismatch shows address, then halts
// - bus clock is oscillator divided by two
package bms_pkg;

  // ----------------------------------------------------------------
  // memory map and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_FIRST = 16'h0100;     // first copied byte
  localparam logic [15:0] ADDR_LAST = 16'h1FFF;      // last copied byte
  localparam int PROGRAM_INDICATOR_PULSE_BUS = 4;                 // bus cycles a write is held
  localparam logic [2:0] PROGRAM_INDICATOR_PULSE_CNT = 3'(PROGRAM_INDICATOR_PULSE_BUS);
  localparam logic [7:0] ERASED_BYTE = 8'h00;        // blank eprom value

  // ----------------------------------------------------------------
  // select pin codes, order bit2 bit1 bit0
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_VERIFY = 3'h5;
  localparam logic [2:0] SEL_PROG1 = 3'h6;
  localparam logic [2:0] SEL_PROG4 = 3'h7;

  // operating mode chosen at reset release
  typedef enum logic [1:0]
  {
    MODE_SINGLE = 2'h0,
    MODE_VERIFY = 2'h1,
    MODE_PROG1 = 2'h3,
    MODE_PROG4 = 2'h2
  } bms_mode_e;

  // copier sequence, gray from idle through burn to advance
  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h0,
    ST_LATCH_HI = 4'h1,
    ST_LATCH_LO = 4'h3,
    ST_FETCH = 4'h2,
    ST_BURN = 4'h6,
    ST_ADVANCE = 4'h7,
    ST_ERR_HI = 4'h5,
    ST_ERR_LO = 4'h4,
    ST_HALT = 4'hC,
    ST_DONE = 4'hD
  } bms_state_e;

  // external address latch port
  typedef struct packed
  {
    logic [7:0] data;  // port value presented to the latches
    logic load_hi;     // strobe for the high address latch
    logic load_lo;     // strobe for the low address latch
  } bms_latch_s;

  // on-chip eprom write request
  typedef struct packed
  {
    logic [15:0] addr;   // byte address, also read address
    logic [31:0] wdata;  // up to four bytes, byte 0 in low lane
    logic wide;          // four bytes at once
    logic wr_en;         // programming pulse active
  } bms_eprom_s;

endpackage

/* core/bms_top.sv */
// boot mode selection and bootloader copier from external eprom
// assumes synchronous pins, external latches and eprom answering within one bus cycle
`timescale 1ns/1ps
module bms_top
(
  input wire logic clock,                      // 20 MHz oscillator clock
  input wire logic rst_n,                      // synchronous reset, active low
  input wire logic vpp_high,                   // irq/vpp pin at programming level
  input wire logic boot_select_bit0,           // mode select pin 0
  input wire logic boot_select_bit1,           // mode select pin 1
  input wire logic boot_select_bit2,           // mode select pin 2
  input wire logic [7:0] ext_data,             // external eprom data
  input wire logic [7:0] int_rd_data,          // on-chip eprom read data
  output bms_pkg::bms_latch_s latch_port,      // external address latch drive
  output bms_pkg::bms_eprom_s eprom_req,       // on-chip eprom access
  output logic portc_bit0_pin,                 // program indicator pin
  output logic portc_bit1_pin,                 // verify ok indicator pin
  output logic single_chip,                    // single chip mode active
  output logic ext_bus_en,                     // bootloader uses external pins
  output logic vec_internal,                   // vectors from on-chip eprom
  output logic halted                          // stopped on verify error
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic bus_ce;                      // half-rate step enable
  logic rel_seen_ff;                 // reset release already handled
  bms_pkg::bms_mode_e mode_ff;       // captured operating mode
  bms_pkg::bms_state_e state_ff;     // copier state
  bms_pkg::bms_state_e nxt_state;    // next copier state
  logic pass_verify_ff;              // second pass running
  logic [15:0] addr_ff;              // current copy address
  logic [15:0] base_ff;              // first address of write group
  logic [1:0] idx_ff;                // byte slot within group
  logic [2:0] pulse_ff;              // write pulse bus cycles left
  logic group_end;                   // last byte of a write group
  logic [15:0] step_addr;            // address the next high latch load shows
  logic program_indicator_ind_ff;                 // program indicator
  logic ver_ind_ff;                  // verify indicator

  // pick the mode from the pins
  function automatic bms_pkg::bms_mode_e decode_mode(input logic vpp, input logic [2:0] sel);
    decode_mode = bms_pkg::MODE_SINGLE;
    if (vpp && sel == bms_pkg::SEL_VERIFY)
      decode_mode = bms_pkg::MODE_VERIFY;
    else if (vpp && sel == bms_pkg::SEL_PROG1)
      decode_mode = bms_pkg::MODE_PROG1;
    else if (vpp && sel == bms_pkg::SEL_PROG4)
      decode_mode = bms_pkg::MODE_PROG4;
  endfunction

  bms_clkdiv u_div
  (
    .clock(clock),
    .rst_n(rst_n),
    .bus_ce(bus_ce)
  );

  // ----------------------------------------------------------------
  // mode capture at reset release
  // ----------------------------------------------------------------
  // pins are sampled on the first clock after release, never under reset
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rel_seen_ff <= 1'b0;
      mode_ff <= bms_pkg::MODE_SINGLE;
    end
    else if (!rel_seen_ff)
    begin
      rel_seen_ff <= 1'b1;
      // unlisted selects with high vpp fall back to single chip
      mode_ff <= decode_mode(vpp_high, {boot_select_bit2, boot_select_bit1, boot_select_bit0});
    end
  end

  // mode flags toward the rest of the chip
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      single_chip <= 1'b0;
      ext_bus_en <= 1'b0;
      vec_internal <= 1'b0;
    end
    else if (rel_seen_ff)
    begin
      single_chip <= (mode_ff == bms_pkg::MODE_SINGLE);
      ext_bus_en <= (mode_ff != bms_pkg::MODE_SINGLE);
      vec_internal <= (mode_ff == bms_pkg::MODE_SINGLE);
    end
  end

  // ----------------------------------------------------------------
  // copier sequence
  // ----------------------------------------------------------------
  // group closes after 4 bytes in wide mode, every byte otherwise, or at the end
  assign group_end = (mode_ff != bms_pkg::MODE_PROG4) || (idx_ff == 2'h3) || (addr_ff == bms_pkg::ADDR_LAST);

  // advance updates the address on the same edge that loads the high latch,
  // so the high byte must come from the address being stepped to, not the old one
  assign step_addr = (state_ff != bms_pkg::ST_ADVANCE) ? addr_ff
                     : ((addr_ff == bms_pkg::ADDR_LAST) ? bms_pkg::ADDR_FIRST : addr_ff + 16'h0001);

  // next state; the eprom must be blank beforehand, bytes are simply written
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      bms_pkg::ST_IDLE:
        if (rel_seen_ff && mode_ff != bms_pkg::MODE_SINGLE)
          nxt_state = bms_pkg::ST_LATCH_HI;
      bms_pkg::ST_LATCH_HI:
        nxt_state = bms_pkg::ST_LATCH_LO;
      bms_pkg::ST_LATCH_LO:
        nxt_state = bms_pkg::ST_FETCH;
      bms_pkg::ST_FETCH:
        if (pass_verify_ff && ext_data != int_rd_data)
          nxt_state = bms_pkg::ST_ERR_HI;
        else if (!pass_verify_ff && group_end)
          nxt_state = bms_pkg::ST_BURN;
        else
          nxt_state = bms_pkg::ST_ADVANCE;
      bms_pkg::ST_BURN:
        if (pulse_ff == 3'h1)
          nxt_state = bms_pkg::ST_ADVANCE;
      bms_pkg::ST_ADVANCE:
        if (addr_ff == bms_pkg::ADDR_LAST && pass_verify_ff)
          nxt_state = bms_pkg::ST_DONE;
        else
          nxt_state = bms_pkg::ST_LATCH_HI;
      bms_pkg::ST_ERR_HI:
        nxt_state = bms_pkg::ST_ERR_LO;
      bms_pkg::ST_ERR_LO:
        nxt_state = bms_pkg::ST_HALT;
      bms_pkg::ST_HALT:
        nxt_state = bms_pkg::ST_HALT;
      bms_pkg::ST_DONE:
        nxt_state = bms_pkg::ST_DONE;
      default:
        nxt_state = bms_pkg::ST_IDLE;
    endcase
  end

  // state register, stepped at the bus rate
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_ff <= bms_pkg::ST_IDLE;
    else if (bus_ce)
      state_ff <= nxt_state;
  end

  // pass, address and group bookkeeping
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pass_verify_ff <= 1'b0;
      addr_ff <= bms_pkg::ADDR_FIRST;
      base_ff <= bms_pkg::ADDR_FIRST;
      idx_ff <= 2'h0;
    end
    else if (bus_ce)
    begin
      if (state_ff == bms_pkg::ST_IDLE)
        pass_verify_ff <= (mode_ff == bms_pkg::MODE_VERIFY); // verify-only skips programming
      else if (state_ff == bms_pkg::ST_ADVANCE)
      begin
        if (addr_ff == bms_pkg::ADDR_LAST)
        begin
          // whole map programmed, restart from the top for the verify pass
          pass_verify_ff <= 1'b1;
          addr_ff <= bms_pkg::ADDR_FIRST;
          base_ff <= bms_pkg::ADDR_FIRST;
          idx_ff <= 2'h0;
        end
        else
        begin
          // external address advances every byte, the internal base only at a group end or in verify
          addr_ff <= addr_ff + 16'h0001;
          idx_ff <= (!pass_verify_ff && group_end) ? 2'h0 : idx_ff + 2'h1;
          if (pass_verify_ff || group_end)
            base_ff <= addr_ff + 16'h0001;
        end
      end
    end
  end

  // programming pulse length
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      pulse_ff <= 3'h0;
    else if (bus_ce)
      pulse_ff <= (nxt_state == bms_pkg::ST_BURN && state_ff != bms_pkg::ST_BURN) ? bms_pkg::PROGRAM_INDICATOR_PULSE_CNT
                  : (pulse_ff != 3'h0 ? pulse_ff - 3'h1 : 3'h0);
  end

  // ----------------------------------------------------------------
  // external latch and on-chip eprom drive
  // ----------------------------------------------------------------
  // latches are loaded from the port; error address reuses the same path
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      latch_port <= '0;
    else if (bus_ce)
    begin
      latch_port.load_hi <= 1'b0;
      latch_port.load_lo <= 1'b0;
      if (nxt_state == bms_pkg::ST_LATCH_HI || nxt_state == bms_pkg::ST_ERR_HI)
      begin
        latch_port.data <= step_addr[15:8];
        latch_port.load_hi <= 1'b1;
      end
      else if (nxt_state == bms_pkg::ST_LATCH_LO || nxt_state == bms_pkg::ST_ERR_LO)
      begin
        latch_port.data <= addr_ff[7:0];
        latch_port.load_lo <= 1'b1;
      end
    end
  end

  // on-chip eprom address, data gathering and write pulse
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      eprom_req <= '0;
    else if (bus_ce)
    begin
      if (state_ff == bms_pkg::ST_LATCH_LO)
        eprom_req.addr <= pass_verify_ff ? addr_ff : base_ff;
      if (state_ff == bms_pkg::ST_FETCH && !pass_verify_ff)
        eprom_req.wdata[8 * idx_ff +: 8] <= ext_data;
      eprom_req.wide <= (mode_ff == bms_pkg::MODE_PROG4);
      eprom_req.wr_en <= (nxt_state == bms_pkg::ST_BURN);
    end
  end

  // ----------------------------------------------------------------
  // indicators
  // ----------------------------------------------------------------
  // program lamp lit during the programming pass, dark once verify starts
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      program_indicator_ind_ff <= 1'b0;
      ver_ind_ff <= 1'b0;
    end
    else if (bus_ce)
    begin
      program_indicator_ind_ff <= !pass_verify_ff && state_ff != bms_pkg::ST_IDLE
                     && !(state_ff == bms_pkg::ST_ADVANCE && addr_ff == bms_pkg::ADDR_LAST);
      ver_ind_ff <= (nxt_state == bms_pkg::ST_DONE);
    end
  end

  // pins follow the lamps only in bootloader mode; halt flag mirrors state
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      portc_bit0_pin <= 1'b0;
      portc_bit1_pin <= 1'b0;
      halted <= 1'b0;
    end
    else
    begin
      portc_bit0_pin <= program_indicator_ind_ff && mode_ff != bms_pkg::MODE_SINGLE;
      portc_bit1_pin <= ver_ind_ff && mode_ff != bms_pkg::MODE_SINGLE;
      halted <= (state_ff == bms_pkg::ST_HALT);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_halt_sticky : assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == bms_pkg::ST_HALT |=> state_ff == bms_pkg::ST_HALT && $stable(latch_port.data))
    else $error("halt left or error address changed");

  chk_mode_stable : assert property (@(posedge clock) disable iff (!rst_n)
    rel_seen_ff |=> $stable(mode_ff))
    else $error("mode changed after reset release");

  chk_single_quiet : assert property (@(posedge clock) disable iff (!rst_n)
    single_chip |-> !latch_port.load_hi && !latch_port.load_lo && !eprom_req.wr_en && !ext_bus_en)
    else $error("external activity in single chip mode");

  chk_program_indicator_dark_verify : assert property (@(posedge clock) disable iff (!rst_n)
    pass_verify_ff && state_ff == bms_pkg::ST_LATCH_HI |-> ##[0:4] !program_indicator_ind_ff)
    else $error("program indicator lit during verify");

  chk_burn_program_indicator_pass : assert property (@(posedge clock) disable iff (!rst_n)
    eprom_req.wr_en |-> !pass_verify_ff)
    else $error("write pulse during verify pass");

  chk_verify_done : assert property (@(posedge clock) disable iff (!rst_n)
    $rose(ver_ind_ff) |-> state_ff == bms_pkg::ST_DONE && pass_verify_ff)
    else $error("verify indicator without completed verify");

  chk_err_no_ok : assert property (@(posedge clock) disable iff (!rst_n)
    state_ff == bms_pkg::ST_ERR_HI |-> ##[1:6] state_ff == bms_pkg::ST_HALT ##0 !ver_ind_ff)
    else $error("mismatch did not halt cleanly");

  chk_pins_follow : assert property (@(posedge clock) disable iff (!rst_n)
    rel_seen_ff && mode_ff != bms_pkg::MODE_SINGLE |=> portc_bit0_pin == $past(program_indicator_ind_ff))
    else $error("program pin does not follow indicator");

endmodule

/* testbench/bms_partner.sv */
// far side model: external eprom behind two address latches, plus the on-chip eprom array
// assumes strobes and requests come from copier registers, taken on the rising edge
`timescale 1ns/1ps
module bms_partner
(
  input wire logic clock,                      // oscillator clock
  input wire logic [7:0] salt,                 // seed of the code image
  input wire bms_pkg::bms_latch_s latch_port,  // latch drive from the copier
  input wire bms_pkg::bms_eprom_s eprom_req,   // on-chip eprom access
  output logic [7:0] ext_data,                 // external eprom data
  output logic [7:0] int_rd_data,              // on-chip eprom read data
  output logic [15:0] ext_addr                 // address held by the latches
);
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535]; // on-chip array
  logic wr_prev = 1'b0; // write pulse seen last cycle

  // array starts blank, before any programming pass
  initial
  begin
    ext_addr <= 16'h0000;
    foreach (mem[i])
      mem[i] <= bms_pkg::ERASED_BYTE;
  end

  // image laid out on the internal map, so both counters meet
  assign ext_data = ext_addr[7:0] ^ {ext_addr[12:8], 3'h0} ^ salt;
  assign int_rd_data = mem[eprom_req.addr];

  // latches load from the port strobes; a burn only sets bits, like real cells
  always @(posedge clock)
  begin
    if (latch_port.load_hi)
      ext_addr[15:8] <= latch_port.data;
    if (latch_port.load_lo)
      ext_addr[7:0] <= latch_port.data;
    wr_prev <= eprom_req.wr_en;
    if (eprom_req.wr_en && !wr_prev)
      for (int k = 0; k < 4; k++)
        if (k == 0 || eprom_req.wide)
          mem[eprom_req.addr + 16'(k)] <= mem[eprom_req.addr + 16'(k)] | eprom_req.wdata[8*k +: 8];
  end

  // backdoor fill with the image, bit 0 of the byte at bad flipped where bad lies in range
  task automatic fill(input logic [15:0] bad);
    for (int a = bms_pkg::ADDR_FIRST; a <= bms_pkg::ADDR_LAST; a++)
      mem[a] <= 8'(a) ^ {5'(a >> 8), 3'h0} ^ salt ^ ((16'(a) == bad) ? 8'h01 : 8'h00);
  endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the boot mode selector and eprom copier
// assumes bms_partner stands for the external eprom, its latches and the on-chip array
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock; // 20 MHz clock
  logic rst_n; // reset, active low
  logic vpp_high; // programming level on irq pin
  logic boot_select_bit0, boot_select_bit1, boot_select_bit2; // select pins
  logic [7:0] ext_data, int_rd_data, salt; // data paths and image seed
  bms_pkg::bms_latch_s latch_port; // latch drive
  bms_pkg::bms_eprom_s eprom_req; // on-chip access
  logic portc_bit0_pin, portc_bit1_pin, single_chip, ext_bus_en, vec_internal, halted; // flags
  logic [15:0] ext_addr, bad; // latched address, corrupted byte
  logic [48:0] exp_wr[$], wn; // wide, addr, wdata per expected burn
  logic [16:0] exp_end[$], en; // halt flag and error address
  logic wr_prev, halt_prev, ok_prev, bm; // edge memory, bootloader expected
  int failures = 0;
  int checks = 0;
  int cycles = 0;

  bms_top dut (.clock, .rst_n, .vpp_high, .boot_select_bit0, .boot_select_bit1, .boot_select_bit2,
    .ext_data, .int_rd_data, .latch_port, .eprom_req, .portc_bit0_pin, .portc_bit1_pin,
    .single_chip, .ext_bus_en, .vec_internal, .halted);
  bms_partner u_part (.clock, .salt, .latch_port, .eprom_req, .ext_data, .int_rd_data, .ext_addr);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever
      #25 clock = ~clock;
  end

  function automatic logic [7:0] img(input logic [15:0] a);
    return a[7:0] ^ {a[12:8], 3'h0} ^ salt;
  endfunction

  task automatic chk_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // pins set while reset is held, then released; pins stay until the next call
  task automatic boot(input logic vpp, input logic [2:0] sel);
    @(posedge clock);
    #5 rst_n = 1'b0;
    vpp_high = vpp;
    {boot_select_bit2, boot_select_bit1, boot_select_bit0} = sel;
    repeat (2) @(posedge clock);
    #5 rst_n = 1'b1;
  endtask

  // start a programming mode, note the first n burns, wait until all were seen
  task automatic program_indicator_run(input logic [2:0] sel, input int n);
    logic [15:0] b;
    for (int g = 0; g < n; g++)
    begin
      b = bms_pkg::ADDR_FIRST + 16'(g * (sel[0] ? 4 : 1));
      exp_wr.push_back({sel[0], b, sel[0] ? {img(b + 16'h3), img(b + 16'h2), img(b + 16'h1), img(b)}
        : {24'h0, img(b)}});
    end
    boot(1'b1, sel);
    while (exp_wr.size() > 0)
      @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // watcher: compares each burn or end of verify with the oldest note
  // ----------------------------------------------------------------
  always @(negedge clock)
  begin
    if (eprom_req.wr_en === 1'b1 && wr_prev !== 1'b1 && exp_wr.size() > 0)
    begin
      wn = exp_wr.pop_front();
      chk_word("burn addr", 32'(wn[47:32]), 32'(eprom_req.addr));
      chk_flag("burn wide", wn[48], eprom_req.wide);
      chk_word("burn data", wn[31:0], wn[48] ? eprom_req.wdata : {24'h0, eprom_req.wdata[7:0]});
      chk_flag("program indicator", 1'b1, portc_bit0_pin);
    end
    if (((halted === 1'b1 && halt_prev !== 1'b1) || (portc_bit1_pin === 1'b1 && ok_prev !== 1'b1))
      && exp_end.size() > 0)
    begin
      en = exp_end.pop_front();
      chk_flag("halted", en[16], halted);
      chk_flag("verify ok", !en[16], portc_bit1_pin);
      if (en[16])
        chk_word("error address", 32'(en[15:0]), 32'(ext_addr));
    end
    wr_prev = eprom_req.wr_en;
    halt_prev = halted;
    ok_prev = portc_bit1_pin;
  end

  // hang guard; a full verify pass is about 64k cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      failures++;
      $display("BAD run length expected end seen none");
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    vpp_high = 1'b0;
    {boot_select_bit2, boot_select_bit1, boot_select_bit0} = 3'h0;
    void'($urandom(32'h211e6d67));
    salt = 8'($urandom);
    // every pin level and code; late pin changes must not matter
    for (int i = 0; i < 16; i++)
    begin
      boot(i[3], 3'(i));
      bm = i[3] && (3'(i) inside {bms_pkg::SEL_VERIFY, bms_pkg::SEL_PROG1, bms_pkg::SEL_PROG4});
      @(posedge clock);
      #5 {vpp_high, boot_select_bit2, boot_select_bit1, boot_select_bit0} = 4'($urandom);
      repeat (5) @(posedge clock);
      #5;
      chk_flag("single_chip", !bm, single_chip);
      chk_flag("ext_bus_en", bm, ext_bus_en);
      chk_flag("vec_internal", !bm, vec_internal);
      chk_flag("portc_bit0_pin", bm && 3'(i) != bms_pkg::SEL_VERIFY, portc_bit0_pin);
    end
    $display("done mode select");
    program_indicator_run(bms_pkg::SEL_PROG4, 3);
    program_indicator_run(bms_pkg::SEL_PROG1, 5);
    $display("done programming");
    // mismatch near the start: halt with the address shown, held
    bad = bms_pkg::ADDR_FIRST + 16'($urandom_range(63));
    u_part.fill(bad);
    exp_end.push_back({1'b1, bad});
    boot(1'b1, bms_pkg::SEL_VERIFY);
    while (exp_end.size() > 0)
      @(posedge clock);
    repeat (100) @(posedge clock);
    #5;
    chk_flag("halted held", 1'b1, halted);
    chk_word("address held", 32'(bad), 32'(ext_addr));
    chk_flag("verify ok held", 1'b0, portc_bit1_pin);
    chk_flag("program off", 1'b0, portc_bit0_pin);
    $display("done verify mismatch");
    // clean copy: whole range compared, indicator set
    u_part.fill(16'h0000);
    exp_end.push_back({1'b0, 16'h0000});
    boot(1'b1, bms_pkg::SEL_VERIFY);
    while (exp_end.size() > 0)
      @(posedge clock);
    #5;
    chk_flag("not halted", 1'b0, halted);
    $display("done verify pass");
    tally_and_finish();
  end
endmodule
